/* hw/ddc_pkg.sv */
package ddc_pkg;
  localparam logic [2:0] CMD_DUMP = 3'h6;
  localparam int CMD_LSB = 16;
  localparam int BIT_EL = 31;
  localparam int BIT_SUSP = 30;
  localparam int BIT_IRQ = 29;
  localparam int BIT_DONE = 15;
  localparam int BIT_OK = 13;
  localparam int DUMP_BYTES = 596;
  localparam int FRAME_EXTRACTION_UNIT_BYTES = 24;
  localparam int IMG_BYTES = 80;
  localparam int FIFO_DEPTH = 32;
  localparam logic [7:0] DUMP_CMD_BYTE = 8'h06;
  localparam logic [7:0] DUMP_MARKER = 8'hd5;
  localparam logic [31:0] OFS_LINK = 32'h0000_0004;
  localparam logic [31:0] OFS_BUF = 32'h0000_0008;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RD0 = 4'b0001,
    ST_RD1 = 4'b0010,
    ST_RD2 = 4'b0011,
    ST_DECODE = 4'b0100,
    ST_TXCMD = 4'b0101,
    ST_MARK = 4'b0110,
    ST_COPY = 4'b0111,
    ST_DRAIN = 4'b1000,
    ST_STATUS = 4'b1001,
    ST_FINISH = 4'b1010,
    ST_SUSP = 4'b1011
  } ddc_state_e;
endpackage

/* hw/ddc_fifo.sv */
`timescale 1ns/10ps
module ddc_fifo
  import ddc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // clock
  input wire logic nrst, // sync reset
  input wire logic in_valid, // write request
  output logic in_ready, // space left
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data present
  input wire logic out_ready, // read accept
  output logic [WIDTH-1:0] out_data // head data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  chk_fifo_bound: assert property (@(posedge clk) disable iff (!nrst)
    cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

/* hw/ddc_wordpack.sv */
`timescale 1ns/10ps
module ddc_wordpack
  import ddc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // sync reset
  input wire logic clr, // restart packing
  input wire logic in_valid, // byte available
  output logic in_ready, // byte taken
  input wire logic [7:0] in_byte, // byte in
  output logic out_valid, // word ready
  input wire logic out_ready, // word taken
  output logic [31:0] out_word // packed word, first byte low
);
  logic [31:0] acc, next_acc;
  logic [1:0] lane, next_lane;
  logic full, next_full;
  always_comb begin
    next_acc = acc;
    next_lane = lane;
    next_full = full;
    if (full && out_ready) begin
      next_full = 1'b0;
    end
    if (in_valid && in_ready) begin
      next_acc[lane*8 +: 8] = in_byte;
      next_lane = lane + 2'd1;
      if (lane == 2'd3) begin
        next_full = 1'b1;
      end
    end
    if (clr) begin
      next_lane = '0;
      next_full = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc <= '0;
      lane <= '0;
      full <= 1'b0;
    end else begin
      acc <= next_acc;
      lane <= next_lane;
      full <= next_full;
    end
  end
  assign in_ready = !full;
  assign out_valid = full;
  assign out_word = acc;
endmodule

/* hw/ddc_dump_cmd.sv */
`timescale 1ns/10ps
// Overview of operation
// - command field 18:16 equal to 110b starts the dump sequence
// - next block address is link field plus command unit base
// - end-of-list flag: go idle and always raise not-active interrupt
// - suspend flag: suspend; not-active interrupt only if configured
// - interrupt flag raises command-executed interrupt, else none
// - software clears completion bit 15; device sets it when done
// - bit 13 one reports success; zero with completion means failure
// - third word is the dump area address, used without the command unit base; 596 bytes written there
// - send dump command byte to transmit fifo, wait for marker
// - copy extraction registers via status fifo, then mac registers from the parallel image
// - final status word has completion bit set; success bit set unless an unknown command was seen since start
// - bytes 0 to 23 hold extraction pointers, counters, thresholds
// - bytes 24-37 config 8-21, 38 reserved, 39-42 address 1-4
// - bytes 43-76 address 5-6, status, crcs, hash, length; 77-79 reserved
module ddc_dump_cmd
  import ddc_pkg::*;
(
  input wire logic clk, // 25 mhz clock
  input wire logic nrst, // sync reset, active low
  input wire logic start, // start command unit pulse
  input wire logic [31:0] start_addr, // first block address offset
  input wire logic [31:0] cu_base, // command unit base
  input wire logic cna_on_suspend, // config: not-active irq on suspend
  input wire logic resume, // leave suspended state
  output logic mem_req, // memory access request
  output logic mem_we, // write when high
  output logic [31:0] mem_addr, // byte address
  output logic [31:0] mem_wdata, // write data
  input wire logic mem_ack, // access done
  input wire logic [31:0] mem_rdata, // read data
  output logic tx_valid, // transmit fifo byte valid
  output logic [7:0] tx_byte, // transmit fifo byte
  input wire logic tx_ready, // transmit fifo space
  input wire logic st_valid, // status fifo byte valid
  input wire logic [7:0] st_byte, // status fifo byte
  output logic st_ready, // status fifo accept
  input wire logic [IMG_BYTES*8-1:0] par_regs, // parallel register image, byte 0 low
  output logic irq_cx, // command executed pulse
  output logic irq_cna, // unit not active pulse
  output logic cu_active, // unit active
  output logic cu_suspended, // unit suspended
  output logic cmd_error // unknown command seen
);
  ddc_state_e st, next_st;
  logic [31:0] blk, next_blk, link, next_link, bufp, next_bufp, w0, next_w0;
  logic [9:0] bcnt, next_bcnt;
  logic next_mem_req, next_mem_we, next_tx_valid, next_irq_cx, next_irq_cna;
  logic next_act, next_susp, next_err;
  logic [31:0] next_mem_addr, next_mem_wdata;
  logic [7:0] next_tx_byte;
  logic next_st_ready;
  // byte stream into the packer: status fifo first, then parallel image, then zero fill
  logic src_valid, src_ready, f_out_valid, f_out_ready, pk_valid, pk_ready, pk_clr;
  logic [7:0] src_byte, f_out_byte;
  logic [31:0] pk_word;
  logic f_in_ready;

  function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
    add32 = a + b;
  endfunction

  ddc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(src_valid),
    .in_ready(f_in_ready),
    .in_data(src_byte),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_byte)
  );

  ddc_wordpack u_pack (
    .clk(clk),
    .nrst(nrst),
    .clr(pk_clr),
    .in_valid(f_out_valid),
    .in_ready(f_out_ready),
    .in_byte(f_out_byte),
    .out_valid(pk_valid),
    .out_ready(pk_ready),
    .out_word(pk_word)
  );

  assign pk_clr = (st == ST_DECODE);
  assign src_ready = f_in_ready;

  always_comb begin
    src_valid = 1'b0;
    src_byte = 8'h00;
    if (st == ST_COPY) begin
      if (bcnt < 10'(FRAME_EXTRACTION_UNIT_BYTES)) begin
        // fifo starts each dump empty and these are its first 24 bytes, so it has room
        src_valid = st_valid && st_ready;
        src_byte = st_byte;
      end else if (bcnt < 10'(IMG_BYTES)) begin
        src_valid = 1'b1;
        src_byte = par_regs[bcnt*8 +: 8];
      end else begin
        src_valid = 1'b1; // remaining dump words carry no data here
      end
    end
  end

  always_comb begin
    next_st = st;
    next_blk = blk;
    next_link = link;
    next_bufp = bufp;
    next_w0 = w0;
    next_bcnt = bcnt;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_tx_valid = tx_valid;
    next_tx_byte = tx_byte;
    next_irq_cx = 1'b0;
    next_irq_cna = 1'b0;
    next_act = cu_active;
    next_susp = cu_suspended;
    next_err = cmd_error;
    pk_ready = 1'b0;
    case (st)
      ST_IDLE: begin
        if (start) begin
          next_blk = add32(cu_base, start_addr);
          next_act = 1'b1;
          next_err = 1'b0;
          next_st = ST_RD0;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_addr = add32(cu_base, start_addr);
        end
      end
      ST_RD0: begin
        if (mem_ack) begin
          next_w0 = mem_rdata;
          next_mem_addr = add32(blk, OFS_LINK);
          next_st = ST_RD1;
        end
      end
      ST_RD1: begin
        if (mem_ack) begin
          next_link = add32(cu_base, mem_rdata);
          next_mem_addr = add32(blk, OFS_BUF);
          next_st = ST_RD2;
        end
      end
      ST_RD2: begin
        if (mem_ack) begin
          next_bufp = mem_rdata;
          next_mem_req = 1'b0;
          next_st = ST_DECODE;
        end
      end
      ST_DECODE: begin
        next_bcnt = '0;
        if (w0[CMD_LSB +: 3] == CMD_DUMP) begin
          next_tx_valid = 1'b1;
          next_tx_byte = DUMP_CMD_BYTE;
          next_st = ST_TXCMD;
        end else begin
          next_err = 1'b1; // reported as failed completion
          next_st = ST_STATUS;
        end
      end
      ST_TXCMD: begin
        if (tx_ready) begin
          next_tx_valid = 1'b0;
          next_st = ST_MARK;
        end
      end
      ST_MARK: begin
        if (st_valid && st_byte == DUMP_MARKER) begin
          next_st = ST_COPY;
        end
      end
      ST_COPY: begin
        if (src_valid && src_ready) begin
          next_bcnt = bcnt + 10'd1;
          if (bcnt == 10'(DUMP_BYTES - 1)) begin
            next_st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (!f_out_valid && !pk_valid && !mem_req) begin
          next_st = ST_STATUS;
        end
      end
      ST_STATUS: begin
        if (!mem_req) begin
          next_mem_req = 1'b1;
          next_mem_we = 1'b1;
          next_mem_addr = blk;
          next_mem_wdata = w0;
          next_mem_wdata[BIT_DONE] = 1'b1;
          next_mem_wdata[BIT_OK] = !cmd_error;
        end else if (mem_ack) begin
          next_mem_req = 1'b0;
          next_st = ST_FINISH;
        end
      end
      ST_FINISH: begin
        next_irq_cx = w0[BIT_IRQ];
        if (w0[BIT_EL]) begin
          next_irq_cna = 1'b1;
          next_act = 1'b0;
          next_st = ST_IDLE;
        end else if (w0[BIT_SUSP]) begin
          next_irq_cna = cna_on_suspend;
          next_act = 1'b0;
          next_susp = 1'b1;
          next_st = ST_SUSP;
        end else begin
          next_blk = link;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_addr = link;
          next_st = ST_RD0;
        end
      end
      ST_SUSP: begin
        if (resume) begin
          next_susp = 1'b0;
          next_act = 1'b1;
          next_blk = link;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_addr = link;
          next_st = ST_RD0;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    // word writes into the dump area while copying
    if ((st == ST_COPY || st == ST_DRAIN) && pk_valid) begin
      if (!mem_req) begin
        next_mem_req = 1'b1;
        next_mem_we = 1'b1;
        next_mem_addr = bufp;
        next_mem_wdata = pk_word;
      end else if (mem_ack) begin
        next_mem_req = 1'b0;
        pk_ready = 1'b1;
        next_bufp = add32(bufp, 32'h0000_0004);
      end
    end
    // ready is registered, so it follows the state being entered
    next_st_ready = (next_st == ST_MARK) || (next_st == ST_COPY && next_bcnt < 10'(FRAME_EXTRACTION_UNIT_BYTES));
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= ST_IDLE;
      blk <= '0;
      link <= '0;
      bufp <= '0;
      w0 <= '0;
      bcnt <= '0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      tx_valid <= 1'b0;
      tx_byte <= '0;
      irq_cx <= 1'b0;
      irq_cna <= 1'b0;
      cu_active <= 1'b0;
      cu_suspended <= 1'b0;
      cmd_error <= 1'b0;
      st_ready <= 1'b0;
    end else begin
      st <= next_st;
      blk <= next_blk;
      link <= next_link;
      bufp <= next_bufp;
      w0 <= next_w0;
      bcnt <= next_bcnt;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
      irq_cx <= next_irq_cx;
      irq_cna <= next_irq_cna;
      cu_active <= next_act;
      cu_suspended <= next_susp;
      cmd_error <= next_err;
      st_ready <= next_st_ready;
    end
  end

  chk_cx_needs_i: assert property (@(posedge clk) disable iff (!nrst)
    irq_cx |-> $past(w0[BIT_IRQ]) && $past(st == ST_FINISH)) else $error("cx irq without request flag");
  chk_el_raises_cna: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_FINISH && w0[BIT_EL]) |=> irq_cna && !cu_active) else $error("end of list missed cna");
  chk_susp_state: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_FINISH && !w0[BIT_EL] && w0[BIT_SUSP]) |=> cu_suspended && (irq_cna == $past(cna_on_suspend)))
    else $error("suspend handling wrong");
  chk_status_bits: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_STATUS && mem_req && mem_we) |-> mem_wdata[BIT_DONE] && (mem_wdata[BIT_OK] == !cmd_error))
    else $error("status word bits wrong");
  chk_dump_decode: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_DECODE && w0[CMD_LSB +: 3] == CMD_DUMP) |=> tx_valid && tx_byte == DUMP_CMD_BYTE)
    else $error("dump code not decoded");
  chk_link_add: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_RD1 && mem_ack) |=> link == $past(cu_base) + $past(mem_rdata)) else $error("link address wrong");
  chk_next_fetch: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_FINISH && !w0[BIT_EL] && !w0[BIT_SUSP]) |=> st == ST_RD0 && mem_addr == $past(link))
    else $error("next block not fetched");
  chk_copy_waits: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_MARK && !(st_valid && st_byte == DUMP_MARKER)) |=> st == ST_MARK) else $error("copy before marker");
  chk_copy_count: assert property (@(posedge clk) disable iff (!nrst)
    (st == ST_COPY) |-> bcnt < 10'(DUMP_BYTES)) else $error("dump length overrun");
  chk_status_accept: assert property (@(posedge clk) disable iff (!nrst)
    (st_valid && st_ready) |-> (st == ST_MARK || (st == ST_COPY && bcnt < 10'(FRAME_EXTRACTION_UNIT_BYTES) && f_in_ready)))
    else $error("status byte taken out of phase");
endmodule

/* sim/ddc_host_mem.sv */
`timescale 1ns/10ps
module ddc_host_mem (
  input wire logic clk, // clock
  input wire logic slow, // three wait cycles per access
  input wire logic mem_req, // access request
  input wire logic mem_we, // write when high
  input wire logic [31:0] mem_addr, // byte address
  input wire logic [31:0] mem_wdata, // write data
  output logic mem_ack, // access done pulse
  output logic [31:0] mem_rdata // read data
);
  logic [31:0] mem [int unsigned];
  int delay;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    delay = 0;
    forever begin
      @(negedge clk);
      if (mem_ack) begin
        mem_ack = 1'b0;
        // read data does not linger once the answer has passed
        mem_rdata = ~mem_rdata;
      end else if (mem_req === 1'b1) begin
        if (delay < (slow ? 3 : 0)) begin
          delay++;
        end else begin
          delay = 0;
          if (mem_we)
            mem[mem_addr] = mem_wdata;
          else
            mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
          mem_ack = 1'b1;
        end
      end
    end
  end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import ddc_pkg::*;
  logic clk, nrst, start, cna_on_suspend, resume, tx_ready, st_valid, slow, took;
  logic mem_req, mem_we, mem_ack, tx_valid, st_ready, irq_cx, irq_cna, cu_active, cu_suspended, cmd_error;
  logic [31:0] start_addr, cu_base, mem_addr, mem_wdata, mem_rdata;
  logic [7:0] st_byte, tx_byte;
  logic [IMG_BYTES*8-1:0] par_regs;
  logic [7:0] fx [24];
  logic [7:0] stq [$];
  int n_fail = 0, compares = 0, n_cx, n_cna, seed = 32'h0000_3d72;

  ddc_dump_cmd dut_u (.clk(clk), .nrst(nrst), .start(start), .start_addr(start_addr), .cu_base(cu_base),
    .cna_on_suspend(cna_on_suspend), .resume(resume), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .st_valid(st_valid), .st_byte(st_byte), .st_ready(st_ready), .par_regs(par_regs),
    .irq_cx(irq_cx), .irq_cna(irq_cna), .cu_active(cu_active), .cu_suspended(cu_suspended), .cmd_error(cmd_error));
  ddc_host_mem host_u (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task summarize;
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (irq_cx === 1'b1) n_cx++;
    if (irq_cna === 1'b1) n_cna++;
    took <= st_valid && st_ready;
    if (tx_valid === 1'b1 && tx_ready) begin
      chk({24'h0000_00, tx_byte}, {24'h0000_00, DUMP_CMD_BYTE}, "tx byte");
      // a stray byte ahead of the marker must be skipped
      stq.push_back(8'h00);
      stq.push_back(DUMP_MARKER);
      foreach (fx[k]) stq.push_back(fx[k]);
    end
  end

  always @(negedge clk) begin
    if (took) void'(stq.pop_front());
    if (!st_valid || took) st_valid = (stq.size() > 0) && ($random(seed) & 1);
    st_byte = st_valid ? stq[0] : ~st_byte;
    tx_ready = $random(seed) & 1;
  end

  function automatic logic [7:0] exp_byte(input int n);
    if (n < FRAME_EXTRACTION_UNIT_BYTES) return fx[n];
    if (n < IMG_BYTES) return par_regs[8*n+:8];
    return 8'h00;
  endfunction

  task automatic newimg;
    foreach (fx[k]) fx[k] = $random(seed);
    for (int k = 0; k < IMG_BYTES; k++) par_regs[8*k+:8] = $random(seed);
  endtask

  task automatic blk(input logic [31:0] a, input logic [2:0] fl, input logic [2:0] cmd, input logic [31:0] link,
                     input logic [31:0] bufa);
    host_u.mem[cu_base + a] = {fl, 10'h000, cmd, 16'h0000};
    host_u.mem[cu_base + a + OFS_LINK] = link;
    host_u.mem[cu_base + a + OFS_BUF] = bufa;
    for (int k = 0; k < DUMP_BYTES; k += 4) host_u.mem[bufa + k] = 32'hffff_ffff;
  endtask

  task automatic go(input logic [31:0] a);
    n_cx = 0;
    n_cna = 0;
    @(negedge clk);
    start_addr = a;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic wait_done(input logic [31:0] a);
    int n;
    n = 0;
    while (host_u.mem[cu_base + a][BIT_DONE] !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) begin
      n_fail++;
      $display("[ERR] %0t block %h never completed", $time, a);
    end
    repeat (4) @(negedge clk);
  endtask

  task automatic chk_dump(input logic [31:0] bufa);
    logic [31:0] w;
    for (int k = 0; k < DUMP_BYTES / 4; k++) begin
      for (int b = 0; b < 4; b++) w[8*b+:8] = exp_byte(4 * k + b);
      chk(host_u.mem[bufa + 4 * k], w, "dump word");
    end
    chk(stq.size(), 0, "status bytes left");
    chk({31'h0000_0000, mem_req}, 32'h0000_0000, "bus busy");
    chk({31'h0000_0000, tx_valid}, 32'h0000_0000, "tx busy");
  endtask

  task automatic chk_st(input logic [31:0] a, input logic [2:0] fl, input logic [2:0] cmd, input logic ok);
    chk(host_u.mem[cu_base + a], {fl, 10'h000, cmd, 1'b1, 1'b0, ok, 13'h0000}, "status word");
  endtask

  initial begin
    nrst = 1'b0;
    start = 1'b0;
    resume = 1'b0;
    start_addr = 32'h0000_0000;
    cu_base = 32'h0000_1000;
    cna_on_suspend = 1'b0;
    slow = 1'b0;
    st_valid = 1'b0;
    st_byte = 8'h00;
    tx_ready = 1'b0;
    par_regs = '0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    newimg();
    blk(32'h0000_0100, 3'b101, CMD_DUMP, 32'h0000_0200, 32'h0000_2000);
    go(32'h0000_0100);
    wait_done(32'h0000_0100);
    chk_dump(32'h0000_2000);
    chk_st(32'h0000_0100, 3'b101, CMD_DUMP, 1'b1);
    chk(n_cx, 1, "cx count");
    chk(n_cna, 1, "cna count");
    chk({31'h0000_0000, cu_active}, 32'h0000_0000, "active");
    for (int c = 0; c < 2; c++) begin
      cna_on_suspend = c[0];
      slow = 1'b1;
      newimg();
      blk(32'h0000_0100, 3'b010, CMD_DUMP, 32'h0000_0200, 32'h0000_2000);
      blk(32'h0000_0200, 3'b101, CMD_DUMP, 32'h0000_0300, 32'h0000_2400);
      go(32'h0000_0100);
      wait_done(32'h0000_0100);
      chk_dump(32'h0000_2000);
      chk(n_cx, 0, "cx count");
      chk(n_cna, c, "cna count");
      chk({31'h0000_0000, cu_suspended}, 32'h0000_0001, "suspended");
      @(negedge clk);
      resume = 1'b1;
      @(negedge clk);
      resume = 1'b0;
      wait_done(32'h0000_0200);
      chk_dump(32'h0000_2400);
      chk(n_cx, 1, "cx count");
      chk(n_cna, c + 1, "cna count");
    end
    slow = 1'b0;
    newimg();
    blk(32'h0000_0100, 3'b001, CMD_DUMP, 32'h0000_0300, 32'h0000_2000);
    blk(32'h0000_0300, 3'b100, 3'h2, 32'h0000_0100, 32'h0000_2800);
    go(32'h0000_0100);
    wait_done(32'h0000_0300);
    chk_dump(32'h0000_2000);
    chk_st(32'h0000_0100, 3'b001, CMD_DUMP, 1'b1);
    chk_st(32'h0000_0300, 3'b100, 3'h2, 1'b0);
    chk(host_u.mem[32'h0000_2800], 32'hffff_ffff, "no dump");
    chk({31'h0000_0000, cmd_error}, 32'h0000_0001, "cmd error");
    chk(n_cx, 1, "cx count");
    chk(n_cna, 1, "cna count");
    summarize();
  end

  initial begin
    #(40 * 40000);
    n_fail++;
    summarize();
  end
endmodule
